/* logic/adcsi_ctrl.sv */
// Purpose: Serial port, conversion cycle and clock selection of a delta-sigma converter
// Assumes: All pins are asynchronous to i_clk; analog core delivers results by valid/ready
// Notes:   Pins are sampled at 200 MHz, far above the 4 MHz serial clock limit
//
// Notes on behaviour
// RULE_01: Clock pin is an input in external mode, driven by device in internal mode.
// RULE_02: Clock mode is taken from clock pin at power up and each select fall.
// RULE_03: Conversion select pin low: conversions timed by internal 307.2 kHz oscillator.
// RULE_04: A clock on the conversion select pin replaces the internal oscillator.
// RULE_05: Select low enables serial logic and wakes the converter.
// RULE_06: After each conversion the device sleeps while select stays high.
// RULE_07: Select rising during result output aborts it and starts a conversion.
// RULE_08: Data output is released whenever select is high.
// RULE_09: During data output the result appears serially on the data output.
// RULE_10: Outside output, data output shows busy high, done low.
// RULE_11: Host polls completion by pulling select low and watching data output.
// RULE_12: Serial input carries gain, rejection, speed, temperature and channel choices.
// RULE_13: Configuration is shifted in during the same transfer that reads the result.
// RULE_14: First conversion after a new selection is already valid.
// RULE_15: Each channel works single-ended or as part of a differential pair.
// RULE_16: Single-ended configurations use the common pin as negative input.
// RULE_17: Out-of-range inputs give distinct over-range and under-range codes.
// RULE_18: Output bits change on falling serial clock edges.
// RULE_19: One input bit per rising edge; transfer ends after 24 bits or select high.
// RULE_20: Select high before first rising edge returns to sleep, no conversion.
// RULE_21: Clock pin low at select fall means external mode, high means internal.
// RULE_22: Captured configuration applies to the next conversion, not the shifted result.
`timescale 1ns/1ps
module adcsi_ctrl #(
  parameter int unsigned P_CONV_TICKS_1X = 41036,
  parameter int unsigned P_CONV_TICKS_2X = 20556
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  // Serial port pins
  input  wire logic                  i_cs_n,
  input  wire logic                  i_sck,
  output logic                       o_sck,
  output logic                       o_sck_oe,
  input  wire logic                  i_serial_config_in,
  output logic                       o_serial_result_out,
  output logic                       o_serial_result_out_oe,
  // Conversion clock select pin
  input  wire logic                  i_conversion_clock_select_pin,
  // Analog core
  output logic                       o_conv_start,
  output adcsi_pkg::adcsi_conv_t     o_conv_cfg,
  input  wire logic                  i_res_valid,
  output logic                       o_res_ready,
  input  wire adcsi_pkg::adcsi_res_t i_res,
  // Status
  output logic                       o_sleep,
  output logic                       o_ext_sck_mode,
  output logic                       o_ext_osc_active
);

  logic [3:0]                 pin_s;
  logic                       cs_s;
  logic                       sck_s;
  logic                       sdi_s;
  logic                       ccs_s;
  logic                       cs_q_r;
  logic                       sck_q_r;
  logic                       ccs_q_r;
  logic                       cs_fall;
  logic                       ccs_rise;
  logic [adcsi_pkg::OSC_CNT_W-1:0]  div_r;
  logic                       int_tick;
  logic [adcsi_pkg::EXT_CNT_W-1:0]  ext_idle_r;
  logic                       ext_act;
  logic                       osc_tick;
  logic                       por_cap_r;
  logic [1:0]                 por_dly_r;
  logic                       ext_mode_r;
  logic                       isck_r;
  logic [adcsi_pkg::ISCK_CNT_W-1:0] isck_cnt_r;
  logic                       isck_flip;
  logic                       rise_ev;
  logic                       fall_ev;
  adcsi_pkg::adcsi_state_t    state_r;
  adcsi_pkg::adcsi_state_t    state_nxt;
  logic [adcsi_pkg::CONV_CNT_W-1:0] conv_cnt_r;
  logic [adcsi_pkg::CONV_CNT_W-1:0] conv_len;
  logic                       conv_elapsed;
  logic                       buf_valid;
  logic                       buf_pop;
  adcsi_pkg::adcsi_res_t      buf_res;
  logic [23:0]                shift_r;
  logic [15:0]                cfg_sh_r;
  logic [adcsi_pkg::BIT_CNT_W-1:0]  bit_cnt_r;
  adcsi_pkg::adcsi_cfg_t      cfg_r;
  adcsi_pkg::adcsi_cfg_t      cfg_nxt;
  logic                       start_conv;
  logic                       sdo_r;
  logic                       start_r;

  // Result word: ordinary codes keep the low five bits zero
  function automatic logic [23:0] fmt_word(input adcsi_pkg::adcsi_res_t r);
    if (r.ovr)
      fmt_word = adcsi_pkg::WORD_OVR;                     // [RULE_17]
    else if (r.udr)
      fmt_word = adcsi_pkg::WORD_UDR;                     // [RULE_17]
    else
      fmt_word = {2'b00, ~r.code[15], r.code, 5'h00};
  endfunction : fmt_word

  // Channel decode for the analog multiplexer
  function automatic adcsi_pkg::adcsi_conv_t decode_cfg(input adcsi_pkg::adcsi_cfg_t c);
    decode_cfg.pos     = {c.addr, c.odd};                 // [RULE_15]
    decode_cfg.neg     = {c.addr, ~c.odd};                // [RULE_15]
    decode_cfg.neg_com = c.sgl;                           // [RULE_16]
    decode_cfg.temp    = c.temp;
    decode_cfg.rej     = c.rej;
    decode_cfg.spd     = c.spd;
    decode_cfg.gain    = c.gain;
  endfunction : decode_cfg

  // Pin synchronisers
  adcsi_sync #(
    .W (4)
  ) u_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async ({i_cs_n, i_sck, i_serial_config_in, i_conversion_clock_select_pin}),
    .o_sync  (pin_s)
  );

  assign cs_s  = pin_s[3] | por_dly_r[1];  // Idle high until the sync holds the pin
  assign sck_s = pin_s[2];
  assign sdi_s = pin_s[1];
  assign ccs_s = pin_s[0];

  // Previous levels for edge detection; select idles high
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cs_q_r  <= 1'b1;
      sck_q_r <= 1'b0;
      ccs_q_r <= 1'b0;
    end
    else
    begin
      cs_q_r  <= cs_s;
      sck_q_r <= sck_s;
      ccs_q_r <= ccs_s;
    end
  end

  assign cs_fall  = cs_q_r & ~cs_s;
  assign ccs_rise = ccs_s & ~ccs_q_r;

  // Internal oscillator as an enable pulse
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      div_r <= '0;
    else if (int_tick)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  assign int_tick = (div_r == adcsi_pkg::OSC_CNT_W'(adcsi_pkg::INT_OSC_DIV - 1)); // [RULE_03]

  // External clock watchdog; a pin tied low never rises and keeps the internal one
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      ext_idle_r <= adcsi_pkg::EXT_CNT_W'(adcsi_pkg::EXT_OSC_TIMEOUT);
    else if (ccs_rise)
      ext_idle_r <= '0;
    else if (int_tick & ~ext_act)
      ext_idle_r <= ext_idle_r;
    else if (int_tick)
      ext_idle_r <= ext_idle_r + 1'b1;
  end

  assign ext_act  = (ext_idle_r < adcsi_pkg::EXT_CNT_W'(adcsi_pkg::EXT_OSC_TIMEOUT));
  assign osc_tick = ext_act ? ccs_rise : int_tick;       // [RULE_04]

  // Clock mode: caught once the syncs hold real pin levels, then at each select fall
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      por_dly_r  <= 2'h3;
      por_cap_r  <= 1'b0;
      ext_mode_r <= 1'b1;
    end
    else
    begin
      por_dly_r <= {por_dly_r[0], 1'b0};
      por_cap_r <= por_dly_r[1] & ~por_dly_r[0];
      if (por_cap_r | cs_fall)
        ext_mode_r <= ~sck_s;                             // [RULE_02] [RULE_21]
    end
  end

  // Internal serial clock: idles high, one half period per four oscillator ticks
  assign isck_flip = (state_r == adcsi_pkg::ST_XFER) & ~ext_mode_r & ~cs_s & osc_tick
                     & (isck_cnt_r == adcsi_pkg::ISCK_CNT_W'(adcsi_pkg::ISCK_HALF_TICKS - 1));

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      isck_r     <= 1'b1;
      isck_cnt_r <= '0;
    end
    else if (state_r != adcsi_pkg::ST_XFER)
    begin
      isck_r     <= 1'b1;
      isck_cnt_r <= '0;
    end
    else if (osc_tick & ~ext_mode_r)
    begin
      isck_cnt_r <= isck_flip ? '0 : isck_cnt_r + 1'b1;
      if (isck_flip)
        isck_r <= ~isck_r;
    end
  end

  // Serial clock edges from whichever source owns the pin
  assign rise_ev = ext_mode_r ? (sck_s & ~sck_q_r) : (isck_flip & ~isck_r);
  assign fall_ev = ext_mode_r ? (~sck_s & sck_q_r) : (isck_flip & isck_r);

  // Result buffer absorbs a core result while the shifter is busy
  adcsi_buf #(
    .W     (adcsi_pkg::RES_W),
    .DEPTH (2)
  ) u_buf (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_valid (i_res_valid),
    .o_ready (o_res_ready),
    .i_data  (i_res),
    .o_valid (buf_valid),
    .i_ready (buf_pop),
    .o_data  (buf_res)
  );

  // Conversion length follows the speed of the running conversion
  assign conv_len = cfg_r.spd ? adcsi_pkg::CONV_CNT_W'(P_CONV_TICKS_2X)
                              : adcsi_pkg::CONV_CNT_W'(P_CONV_TICKS_1X);
  assign conv_elapsed = (conv_cnt_r >= conv_len);
  assign buf_pop      = (state_r == adcsi_pkg::ST_CONV) & conv_elapsed & buf_valid;

  // Conversion timer counts conversion-clock ticks
  always_ff @(posedge i_clk)
  begin
    if (i_srst | start_conv)
      conv_cnt_r <= '0;
    else if ((state_r == adcsi_pkg::ST_CONV) & osc_tick & ~conv_elapsed)
      conv_cnt_r <= conv_cnt_r + 1'b1;                    // [RULE_03] [RULE_04]
  end

  // Cycle control and next configuration
  always_comb
  begin
    state_nxt  = state_r;
    start_conv = 1'b0;
    cfg_nxt    = cfg_r;
    case (state_r)
      adcsi_pkg::ST_CONV:
      begin
        if (buf_pop)
          state_nxt = adcsi_pkg::ST_SLEEP;                // [RULE_06]
      end
      adcsi_pkg::ST_SLEEP:
      begin
        if (~cs_s)
          state_nxt = adcsi_pkg::ST_XFER;                 // [RULE_05]
      end
      adcsi_pkg::ST_XFER:
      begin
        if (cs_s & (bit_cnt_r == '0))
          state_nxt = adcsi_pkg::ST_SLEEP;                // [RULE_20]
        else if (cs_s)
          start_conv = 1'b1;                              // [RULE_07]
        else if (rise_ev & (bit_cnt_r == adcsi_pkg::BIT_CNT_W'(adcsi_pkg::XFER_BITS - 1)))
          start_conv = 1'b1;                              // [RULE_19]
        if (start_conv)
        begin
          state_nxt = adcsi_pkg::ST_CONV;
          // A short frame or a clear enable keeps the old selection
          if ((bit_cnt_r >= adcsi_pkg::BIT_CNT_W'(adcsi_pkg::CFG_BITS)) & cfg_sh_r[15])
            cfg_nxt = adcsi_pkg::adcsi_cfg_t'(cfg_sh_r);  // [RULE_22]
        end
      end
      default:
        state_nxt = adcsi_pkg::ST_CONV;
    endcase
  end

  // State and selection registers; power up starts with a conversion
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_r <= adcsi_pkg::ST_CONV;
      cfg_r   <= adcsi_pkg::CFG_POR;
    end
    else
    begin
      state_r <= state_nxt;
      cfg_r   <= cfg_nxt;
    end
  end

  // Conversion start toward the core, no discarded conversions
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      start_r    <= 1'b0;
      o_conv_cfg <= decode_cfg(adcsi_pkg::CFG_POR);
    end
    else
    begin
      start_r <= start_conv | por_cap_r;                  // [RULE_14]
      if (start_conv)
        o_conv_cfg <= decode_cfg(cfg_nxt);                // [RULE_12]
    end
  end

  // Output shifter: loaded at conversion end, moves on falls after a rise
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      shift_r <= '0;
    else if (buf_pop)
      shift_r <= fmt_word(buf_res);
    else if ((state_r == adcsi_pkg::ST_XFER) & fall_ev & (bit_cnt_r != '0))
      shift_r <= {shift_r[22:0], 1'b0};                   // [RULE_18]
  end

  // Input shifter and bit count; config is taken in the same frame
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cfg_sh_r  <= '0;
      bit_cnt_r <= '0;
    end
    else if (state_r != adcsi_pkg::ST_XFER)
    begin
      cfg_sh_r  <= '0;
      bit_cnt_r <= '0;
    end
    else if (rise_ev & ~cs_s)
    begin
      bit_cnt_r <= bit_cnt_r + 1'b1;                      // [RULE_19]
      if (bit_cnt_r < adcsi_pkg::BIT_CNT_W'(adcsi_pkg::CFG_BITS))
        cfg_sh_r <= {cfg_sh_r[14:0], sdi_s};              // [RULE_13]
    end
  end

  // Data output: result bit while shifting, otherwise busy flag
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      sdo_r <= 1'b1;
    else if (state_nxt == adcsi_pkg::ST_XFER)
      sdo_r <= (state_r == adcsi_pkg::ST_XFER) ? shift_r[23] : 1'b0; // [RULE_09]
    else
      sdo_r <= (state_nxt == adcsi_pkg::ST_CONV);         // [RULE_10]
  end

  // Pin drivers
  assign o_serial_result_out    = sdo_r;
  assign o_serial_result_out_oe = ~cs_s;                  // [RULE_08]
  assign o_sck                  = isck_r;
  assign o_sck_oe = ~ext_mode_r & (state_r == adcsi_pkg::ST_XFER) & ~cs_s; // [RULE_01]

  // Status and core handshake
  assign o_conv_start     = start_r;
  assign o_sleep          = (state_r == adcsi_pkg::ST_SLEEP) & cs_s; // [RULE_06]
  assign o_ext_sck_mode   = ext_mode_r;
  assign o_ext_osc_active = ext_act;

endmodule : adcsi_ctrl

/* logic/adcsi_pkg.sv */
// Purpose: Shared constants and types for the converter serial interface control
// Assumes: 200 MHz system clock, 24-bit result frame, 16-bit configuration word
// Notes:   Conversion lengths are counted in conversion-clock ticks
package adcsi_pkg;

  // System and oscillator rates, in Hz
  localparam int SYS_CLK_HZ   = 200_000_000;
  localparam int INT_OSC_HZ   = 307_200;
  localparam int INT_OSC_DIV  = SYS_CLK_HZ / INT_OSC_HZ;
  localparam int OSC_CNT_W    = 10;

  // Internal serial clock is the conversion clock divided by eight
  localparam int ISCK_HALF_TICKS = 4;
  localparam int ISCK_CNT_W      = 3;

  // Frame layout
  localparam int XFER_BITS  = 24;
  localparam int CFG_BITS   = 16;
  localparam int BIT_CNT_W  = 5;

  // Conversion lengths in conversion-clock ticks (1x and 2x speed)
  localparam int CONV_TICKS_1X = 41036;
  localparam int CONV_TICKS_2X = 20556;
  localparam int CONV_CNT_W    = 16;

  // Internal ticks without an edge before the external clock counts as absent
  localparam int EXT_OSC_TIMEOUT = 64;
  localparam int EXT_CNT_W       = 7;

  // Rejection mode encodings
  localparam logic [1:0] REJ_5060 = 2'h0;
  localparam logic [1:0] REJ_50   = 2'h1;
  localparam logic [1:0] REJ_60   = 2'h2;

  // Out-of-range result words; ordinary words always have bits 4..0 zero
  localparam logic [23:0] WORD_OVR = 24'h3f_ffff;
  localparam logic [23:0] WORD_UDR = 24'h00_001f;

  // Configuration word as shifted in, first bit is en
  typedef struct packed {
    logic       en;
    logic       sgl;
    logic       odd;
    logic [2:0] addr;
    logic       temp;
    logic [1:0] rej;
    logic       spd;
    logic [2:0] gain;
    logic [2:0] rsv;
  } adcsi_cfg_t;

  // Power-on choice: CH0 minus CH1, both line rejections, 1x, gain 1
  localparam adcsi_cfg_t CFG_POR = '{en: 1'b0, sgl: 1'b0, odd: 1'b0, addr: 3'h0,
                                     temp: 1'b0, rej: REJ_5060, spd: 1'b0,
                                     gain: 3'h0, rsv: 3'h0};

  // Settings handed to the analog core with each conversion start
  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] neg;
    logic       neg_com;
    logic       temp;
    logic [1:0] rej;
    logic       spd;
    logic [2:0] gain;
  } adcsi_conv_t;

  // Result from the analog core
  typedef struct packed {
    logic        ovr;
    logic        udr;
    logic [15:0] code;
  } adcsi_res_t;

  localparam int RES_W = 18;

  typedef enum logic [1:0] {
    ST_CONV  = 2'b00,
    ST_SLEEP = 2'b01,
    ST_XFER  = 2'b11
  } adcsi_state_t;

endpackage : adcsi_pkg

/* logic/adcsi_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous pin inputs
// Assumes: Each bit is an independent level
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
module adcsi_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // Levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // Two stages, reset to zero
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule : adcsi_sync

/* logic/adcsi_buf.sv */
// Purpose: Small FIFO between the analog core and the result shifter
// Assumes: Same clock on both sides
// Notes:   Depth two by default; full and empty are exact
`timescale 1ns/1ps
module adcsi_buf #(
  parameter int W     = 18,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // Fill side
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  // Drain side
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic      [W-1:0] o_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  // Stall the filler when full
  assign o_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_valid = (cnt_r != '0);
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  assign o_data  = mem_r[rd_ptr_r];

  // Pointer wrap is explicit so DEPTH need not be a power of two
  function automatic logic [AW-1:0] nxt_ptr(input logic [AW-1:0] p);
    nxt_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : nxt_ptr

  // Storage
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= i_data;
  end

  // Pointers and fill level
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= nxt_ptr(wr_ptr_r);
      if (pop)
        rd_ptr_r <= nxt_ptr(rd_ptr_r);
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule : adcsi_buf

/* testbench/adcsi_chk.sv */
// Purpose: Port-level checks of the converter serial control
// Assumes: Pins pass two sync flops before the logic sees them
// Notes:   Bound onto every adcsi_ctrl instance
`timescale 1ns/1ps
module adcsi_chk #(
  parameter int unsigned P_CONV_TICKS_1X = 41036,
  parameter int unsigned P_CONV_TICKS_2X = 20556
) (
  // Clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_srst,
  // Pins and status
  input wire logic                   i_cs_n,
  input wire logic                   o_sck_oe,
  input wire logic                   o_serial_result_out,
  input wire logic                   o_serial_result_out_oe,
  input wire logic                   o_conv_start,
  input wire adcsi_pkg::adcsi_conv_t o_conv_cfg,
  input wire logic                   o_sleep,
  input wire logic                   o_ext_sck_mode
);
  // One domain; four cycles cover the pin sync latency
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  property p_sdo_rel;
    i_cs_n [*4] |-> !o_serial_result_out_oe;
  endproperty
  a_sdo_rel: assert property (p_sdo_rel)
    else $error("data out driven while deselected");
  property p_sdo_on;
    !i_cs_n [*4] |-> o_serial_result_out_oe;
  endproperty
  a_sdo_on: assert property (p_sdo_on)
    else $error("data out not driven while selected");
  property p_wake;
    !i_cs_n [*4] |-> !o_sleep;
  endproperty
  a_wake: assert property (p_wake)
    else $error("still asleep while selected");
  property p_sleep_idle;
    o_sleep |-> !o_conv_start;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle)
    else $error("conversion started during sleep");
  property p_sck_dir;
    o_sck_oe |-> !o_ext_sck_mode;
  endproperty
  a_sck_dir: assert property (p_sck_dir)
    else $error("clock pin driven in external mode");
  property p_mode_hold;
    !i_cs_n [*6] |=> $stable(o_ext_sck_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("clock mode changed inside a frame");
  property p_cfg_start;
    $changed(o_conv_cfg) |-> o_conv_start;
  endproperty
  a_cfg_start: assert property (p_cfg_start)
    else $error("settings changed without a start");
  property p_busy;
    o_conv_start ##1 o_serial_result_out_oe [*2] |-> o_serial_result_out;
  endproperty
  a_busy: assert property (p_busy)
    else $error("no busy level after a start");
endmodule : adcsi_chk

bind adcsi_ctrl adcsi_chk #(
  .P_CONV_TICKS_1X(P_CONV_TICKS_1X),
  .P_CONV_TICKS_2X(P_CONV_TICKS_2X)
) u_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_cs_n(i_cs_n), .o_sck_oe(o_sck_oe),
  .o_serial_result_out(o_serial_result_out),
  .o_serial_result_out_oe(o_serial_result_out_oe),
  .o_conv_start(o_conv_start), .o_conv_cfg(o_conv_cfg),
  .o_sleep(o_sleep), .o_ext_sck_mode(o_ext_sck_mode)
);

/* testbench/adcsi_host.sv */
// Purpose: Host side of the four-wire serial port
// Assumes: External serial clock, 125 ns link period
// Notes:   Clock stands still between frames
`timescale 1ns/1ps
module adcsi_host (
  // Serial port pins
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  // Idle: deselected, clock low
  initial
  begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_sdi  = 1'b0;
  end
  // Clock level settles well before select moves
  task automatic pins(input logic cs_n, input logic sck);
    o_sck = sck;
    #100;
    o_cs_n = cs_n;
    #100;
  endtask : pins
  // Frame of n rises; config out MSB first, result taken on rises
  task automatic xfer(input int n, input logic [15:0] cfg, output logic [23:0] w);
    w = '0;
    pins(1'b0, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      o_sdi = (i < 16) ? cfg[15 - i] : ~o_sdi;
      #62.5;
      o_sck = 1'b1;
      w[23 - i] = i_sdo;
      #62.5;
      o_sck = 1'b0;
    end
    #100;
    o_cs_n = 1'b1;
    #100;
  endtask : xfer
endmodule : adcsi_host

/* testbench/tb.sv */
// Purpose: Self-checking bench for the converter serial control
// Assumes: Conversion counts cut to 4 and 2 ticks
// Notes:   Host link clock is locked in phase to i_clk; its rises land on i_clk rising edges
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [15:0]           cfg;
    adcsi_pkg::adcsi_res_t res;
    logic [23:0]           word;
  } adcsi_row_t;
  // Config shifted in, core result, word expected out
  localparam adcsi_row_t ROWS [4] = '{
    '{16'hc898, 18'h01234, 24'h224680},
    '{16'ha778, 18'h08001, 24'h100020},
    '{16'hfc00, 18'h20000, 24'h3fffff},
    '{16'h7fff, 18'h1ffff, 24'h00001f}};
  logic                   clk = 1'b0;
  logic                   srst = 1'b1;
  logic                   f0 = 1'b0;
  logic                   f0_en = 1'b0;
  logic                   res_valid = 1'b0;
  adcsi_pkg::adcsi_res_t  res = '0;
  adcsi_pkg::adcsi_conv_t o_cfg;
  adcsi_pkg::adcsi_cfg_t  cur;
  logic                   h_cs_n, h_sck, h_sdi, sck_w, sdo_w;
  logic                   sdo_q = 1'b0;
  logic                   sck_o, sck_oe, serial_result_out, sdo_oe, start;
  logic                   ready, sleep, ext_mode, osc_act;
  logic [23:0]            w;
  int                     n_fail = 0;
  int                     checked = 0;
  int                     n_start = 0;
  int                     n0;
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
  always #2.5 clk = ~clk;
  // Conversion clock on the select pin, only when enabled
  always #500
    if (f0_en)
      f0 = ~f0;
  // Pin levels; released data shows the inverse of its last bit
  assign sck_w = sck_oe ? sck_o : h_sck;
  always @(posedge clk)
    if (sdo_oe)
      sdo_q <= serial_result_out;
  assign sdo_w = sdo_oe ? serial_result_out : ~sdo_q;
  // Start pulses counted to spot missing or extra ones
  always @(posedge clk)
    if (start === 1'b1)
      n_start <= n_start + 1;
  adcsi_host u_host (.o_cs_n(h_cs_n), .o_sck(h_sck), .o_sdi(h_sdi), .i_sdo(sdo_w));
  adcsi_ctrl #(.P_CONV_TICKS_1X(4), .P_CONV_TICKS_2X(2)) u_dut (
    .i_clk(clk), .i_srst(srst), .i_cs_n(h_cs_n), .i_sck(sck_w), .o_sck(sck_o),
    .o_sck_oe(sck_oe), .i_serial_config_in(h_sdi), .o_serial_result_out(serial_result_out),
    .o_serial_result_out_oe(sdo_oe), .i_conversion_clock_select_pin(f0),
    .o_conv_start(start), .o_conv_cfg(o_cfg), .i_res_valid(res_valid),
    .o_res_ready(ready), .i_res(res), .o_sleep(sleep), .o_ext_sck_mode(ext_mode),
    .o_ext_osc_active(osc_act));
  // Core result held until the buffer takes it
  task automatic push(input adcsi_pkg::adcsi_res_t r);
    @(negedge clk);
    res_valid = 1'b1;
    res = r;
    for (int k = 0; k < 50 && ready !== 1'b1; k++)
      @(negedge clk);
    @(negedge clk);
    res_valid = 1'b0;
  endtask : push
  task automatic wsleep();
    for (int k = 0; k < 20000 && sleep !== 1'b1; k++)
      @(negedge clk);
  endtask : wsleep
  task automatic pin(input logic cs_n, input logic sck);
    u_host.pins(cs_n, sck);
    @(negedge clk);
  endtask : pin
  // Only frames of 16 or more bits with the enable bit set replace the settings
  task automatic frame(input int n, input logic [15:0] c);
    u_host.xfer(n, c, w);
    if (n >= 16 && c[15])
      cur = c;
    repeat (20) @(negedge clk);
  endtask : frame
  task automatic chk_cfg();
    logic [7:0] e;
    e = {cur.sgl, cur.temp, cur.rej, cur.spd, cur.gain};
    `CHK("cfg", e, o_cfg[7:0]);
  endtask : chk_cfg
  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  // Watchdog well past the expected 19k cycles
  initial
  begin
    #400000;
    n_fail++;
    finish_test();
  end
  initial
  begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    cur = adcsi_pkg::CFG_POR;
    push(ROWS[0].res);
    `CHK("por cfg", 16'h0100, o_cfg);
    `CHK("int osc", 1'b0, osc_act);
    for (int i = 0; i < 4; i++)
    begin
      if (i > 0)
        push(ROWS[i].res);
      wsleep();
      `CHK("sleep", 1'b1, sleep);
      frame(24, ROWS[i].cfg);
      `CHK("word", ROWS[i].word, w);
      chk_cfg();
      $display("row %0d done", i);
    end
    // Two words fill the buffer while a conversion runs
    push(18'h00abc);
    push(18'h05555);
    `CHK("full", 1'b0, ready);
    pin(1'b0, 1'b0);
    `CHK("busy", 1'b1, sdo_w);
    `CHK("awake", 1'b0, sleep);
    for (int k = 0; k < 20000 && sdo_w !== 1'b0; k++)
      @(negedge clk);
    `CHK("done", 1'b0, sdo_w);
    frame(24, 16'h8000);
    `CHK("poll word", 24'h215780, w);
    chk_cfg();
    $display("poll done");
    // Abort after eight bits keeps the old settings
    wsleep();
    `CHK("hiz", 1'b0, sdo_oe);
    n0 = n_start;
    frame(8, 16'hffff);
    `CHK("abort bits", 8'h2a, w[23:16]);
    `CHK("abort start", n0 + 1, n_start);
    chk_cfg();
    $display("abort done");
    // Clock high at select fall; leave before any rise
    push(18'h00123);
    wsleep();
    n0 = n_start;
    pin(1'b0, 1'b1);
    `CHK("int mode", 1'b0, ext_mode);
    `CHK("sck drive", 1'b1, sck_oe);
    `CHK("sck level", 1'b1, sck_w);
    pin(1'b1, 1'b1);
    `CHK("no start", n0, n_start);
    `CHK("asleep", 1'b1, sleep);
    pin(1'b0, 1'b0);
    `CHK("ext mode", 1'b1, ext_mode);
    pin(1'b1, 1'b0);
    $display("mode done");
    f0_en = 1'b1;
    repeat (2000) @(negedge clk);
    `CHK("ext osc", 1'b1, osc_act);
    f0_en = 1'b0;
    $display("osc done");
    finish_test();
  end
endmodule : tb
